/* verilog/tx_tdm_ingest_path.sv */
// Purpose: transmit tdm ingest path: slot capture, law translation, hdlc de-framing
// Assumes: tdm bus clock and frame pulse come from outside; clock passes four flops, frame pulse three
// Notes:   one byte of each stream is latched per slot; processing walks the list per slot
//
// Operation
// - capture listed slots into external circular buffers
// - up to 1023 pcm or 512 hdlc
// - loopback slots retransmitted onto another slot
// - tag decodes to control or loopback index
// - pairing ignores stream lsb, reads both
// - bits 11:5 slot, 4:0 stream
// - sorted chain, entry0 no tag, sst -1
// - paired hdlc even stream byte first
// - three bit compression code selects format
// - input and output law translation
// - nibble bit places adpcm high or low
// - hdlc header bytes and optional crc
// - hdlc address nine or eight bits
// - hdlc buffer 512 to 32k, size code
// - pcm buffer 256 to 1k via base
// - packet start held in base low part; the code keeps it in the hdlc context packet_start field instead
// - write at offset from packet start, advance
// - read pointer advanced by assembly logic
// - framing bit selects bit or byte oriented
// - completed packet posts an assembly event; the code posts it in byte-oriented framing only, bit-oriented posts none
// - ones counter and history initial values
`timescale 1ns/1ps
module tx_tdm_ingest_path
    import tx_tdm_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 tdm_clk,
    input  wire logic                 tdm_frame,
    input  wire logic [NUM_STREAMS-1:0] tdm_data,
    input  wire logic                 assoc_we,
    input  wire logic [ASSOC_AW-1:0]  assoc_addr,
    input  wire assoc_entry_s         assoc_wdata,
    input  wire logic                 ctrl_we,
    input  wire logic [CTRL_AW-1:0]   ctrl_addr,
    input  wire ctrl_cfg_s            ctrl_wdata,
    input  wire logic                 ctx_init,
    input  wire logic                 rd_ptr_we,
    input  wire logic [CTRL_AW-1:0]   rd_ptr_idx,
    input  wire logic [14:0]          rd_ptr_value,
    input  wire logic                 ssram_ready,
    output ssram_wr_s                 ssram_wr,
    output logic                      ssram_wr_valid,
    output logic                      loop_valid,
    output logic [TAG_W-2:0]          loop_index,
    output logic [7:0]                loop_data,
    output pkt_event_s                pkt_event,
    output logic                      pkt_event_valid,
    output logic                      cfg_error
);

    // ========================================
    // tables
    assoc_entry_s assoc_mem [ASSOC_DEPTH];
    ctrl_cfg_s    ctrl_mem  [CTRL_DEPTH];
    hdlc_ctx_s    ctx_mem   [CTRL_DEPTH];

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_FETCH = 3'b001,
        ST_PROC  = 3'b010,
        ST_ODD   = 3'b011,
        ST_WRITE = 3'b100
    } walk_e;

    typedef struct packed {
        logic [3:0]          clk_sync;
        logic [2:0]          frm_sync;
        logic [2:0][NUM_STREAMS-1:0] dat_sync;
        logic [7:0]          bit_cnt;
        logic [6:0]          slot;
        logic [NUM_STREAMS-1:0][7:0] shift;
        logic [NUM_STREAMS-1:0][7:0] slot_bytes;
        logic                slot_ready;
        walk_e               state;
        logic [ASSOC_AW-1:0] entry;
        assoc_entry_s        cur;
        logic [7:0]          byte_in;
        logic                second;
        ssram_wr_s           wr;
        logic                wr_valid;
        logic                loop_v;
        logic [TAG_W-2:0]    loop_i;
        logic [7:0]          loop_d;
        pkt_event_s          ev;
        logic                ev_v;
        logic                err;
    } state_s;

    state_s s_q;
    state_s s_d;

    // law conversion uses the alternate-bit inversion and keeps the sign bit
    function automatic logic [7:0] law_xlate(input logic [7:0] v, input logic a_to_u);
        logic [7:0] r;
        r = a_to_u ? (v ^ 8'h55) : (v ^ 8'hd5);
        law_xlate = {v[7], r[6:0]};
    endfunction

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] x;
        x = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++)
        begin
            x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
        end
        crc_byte = x;
    endfunction

    // ========================================
    // combinational walk
    ctrl_cfg_s  cfg;
    hdlc_ctx_s  ctx;
    hdlc_ctx_s  ctx_n;
    logic       ctx_we;
    logic [CTRL_AW-1:0] idx;
    logic       tdm_rise;
    logic       frame_seen;
    logic [SSRAM_AW-1:0] span_mask;
    logic [7:0] pcm_out;
    logic [7:0] b;
    logic       wr_req;
    logic [14:0] off;

    assign idx = s_q.cur.tag[CTRL_AW-1:0];
    assign cfg = ctrl_mem[idx];
    assign ctx = ctx_mem[idx];
    assign tdm_rise = (s_q.clk_sync[3:1] == 3'b011);
    assign frame_seen = (s_q.frm_sync[2:1] == 2'b11);

    always_comb
    begin
        s_d = s_q;
        ctx_n = ctx;
        ctx_we = 1'b0;
        wr_req = 1'b0;
        b = s_q.byte_in;
        pcm_out = 8'h00;
        off = 15'h0000;
        span_mask = SSRAM_AW'((22'h000100 << cfg.size_code) - 22'h1);
        s_d.clk_sync = {s_q.clk_sync[2:0], tdm_clk};
        s_d.dat_sync = {s_q.dat_sync[1:0], tdm_data};
        s_d.frm_sync = {s_q.frm_sync[1:0], tdm_frame};
        s_d.ev_v = 1'b0;
        s_d.loop_v = 1'b0;
        if (s_q.wr_valid && ssram_ready)
        begin
            s_d.wr_valid = 1'b0;
        end
        // bit sampling of all streams
        if (tdm_rise)
        begin
            if (frame_seen)
            begin
                s_d.bit_cnt = 8'h00;
                s_d.slot = 7'h7f; // first completed byte becomes slot 0
            end
            else
            begin
                s_d.bit_cnt = s_q.bit_cnt + 8'h01;
            end
            for (int k = 0; k < NUM_STREAMS; k++)
            begin
                s_d.shift[k] = {s_q.shift[k][6:0], s_q.dat_sync[2][k]};
            end
            if (s_d.bit_cnt[2:0] == 3'h7)
            begin
                s_d.slot_bytes = s_d.shift;
                s_d.slot_ready = 1'b1;
                s_d.slot = s_q.slot + 7'h01;
            end
        end
        case (s_q.state)
            ST_IDLE:
            begin
                if (s_q.slot_ready)
                begin
                    s_d.slot_ready = tdm_rise && (s_d.bit_cnt[2:0] == 3'h7);
                    s_d.entry = assoc_mem[0].link;
                    s_d.state = ST_FETCH;
                end
            end
            ST_FETCH:
            begin
                s_d.cur = assoc_mem[s_q.entry];
                // list ends on return to entry 0 or past the current slot
                if (s_q.entry == '0 || assoc_mem[s_q.entry].sst[SST_SLOT_HI:SST_SLOT_LO] > s_q.slot)
                begin
                    s_d.state = ST_IDLE;
                end
                else
                begin
                    s_d.entry = assoc_mem[s_q.entry].link;
                    if (assoc_mem[s_q.entry].sst[SST_SLOT_HI:SST_SLOT_LO] == s_q.slot)
                    begin
                        // pairing forces the even stream first
                        s_d.byte_in = s_q.slot_bytes[{assoc_mem[s_q.entry].sst[SST_STRM_HI:1],
                            assoc_mem[s_q.entry].sst[0] & ~assoc_mem[s_q.entry].paired}];
                        s_d.second = 1'b0;
                        s_d.state = ST_PROC;
                    end
                end
            end
            ST_PROC, ST_ODD:
            begin
                if (s_q.cur.tag[TAG_LOOP_BIT])
                begin
                    s_d.loop_v = 1'b1;
                    s_d.loop_i = s_q.cur.tag[TAG_W-2:0];
                    s_d.loop_d = b;
                end
                else if (!cfg.is_hdlc)
                begin
                    case (cfg.comp)
                        COMP_PCM, COMP_AUTO_ALL: pcm_out = (cfg.in_law == cfg.out_law) ? b
                                                           : law_xlate(b, cfg.in_law);
                        COMP_AD40, COMP_AD32, COMP_AD24, COMP_AD16, COMP_AUTO_AD:
                            pcm_out = cfg.nibble_low ? {4'h0, b[3:0]} : {b[7:4], 4'h0};
                        default: pcm_out = b;
                    endcase
                    s_d.err = s_q.err || (cfg.comp == COMP_RSVD) || (cfg.size_code > PCM_BUF_MAX_CODE);
                    off = ctx.write_offset;
                    ctx_n.write_offset = 15'(span_mask & SSRAM_AW'(ctx.write_offset + 15'h1));
                    ctx_we = 1'b1;
                    wr_req = (cfg.comp != COMP_RSVD);
                    s_d.wr.data = pcm_out;
                end
                else
                begin
                    s_d.err = s_q.err || (cfg.size_code < HDLC_BUF_MIN_CODE);
                    if (cfg.framing_type)
                    begin
                        if (b == HDLC_FLAG)
                        begin
                            if (ctx.in_frame && ctx.write_offset != 15'h0000)
                            begin
                                s_d.ev_v = 1'b1;
                                s_d.ev.stream = 9'(idx);
                                s_d.ev.start = ctx.packet_start;
                                s_d.ev.length = ctx.write_offset;
                                s_d.ev.hdlc_address = ctx.hdlc_address;
                                s_d.ev.crc_bad = cfg.crc_on && (ctx.crc != CRC_GOOD);
                                ctx_n.packet_start = 15'(span_mask & SSRAM_AW'(ctx.packet_start
                                                     + ctx.write_offset));
                            end
                            ctx_n.write_offset = 15'h0000;
                            ctx_n.header_count = 2'h0;
                            ctx_n.hdlc_address = 9'h000;
                            ctx_n.crc = CRC_INIT;
                            ctx_n.escape = 1'b0;
                            ctx_n.in_frame = 1'b1;
                        end
                        else if (b == HDLC_ESC)
                        begin
                            ctx_n.escape = 1'b1;
                        end
                        else if (ctx.in_frame)
                        begin
                            b = ctx.escape ? (b ^ ESC_XOR) : b;
                            ctx_n.escape = 1'b0;
                            ctx_n.crc = crc_byte(ctx.crc, b);
                            if (ctx.header_count < cfg.addr_bytes)
                            begin
                                ctx_n.hdlc_address = (cfg.addr_bytes == 2'h2)
                                    ? {ctx.hdlc_address[0], b} : {1'b0, b};
                            end
                            if (ctx.header_count != 2'h3)
                            begin
                                ctx_n.header_count = ctx.header_count + 2'h1;
                            end
                            off = 15'(span_mask & SSRAM_AW'(ctx.packet_start + ctx.write_offset));
                            ctx_n.write_offset = 15'(span_mask & SSRAM_AW'(ctx.write_offset + 15'h1));
                            wr_req = 1'b1;
                            s_d.wr.data = b;
                        end
                    end
                    else
                    begin
                        // bit-oriented: track ones and history, pending bits behind the leading one
                        ctx_n.history = {ctx.history[6:0], b[7]};
                        ctx_n.ones = (b == 8'hff) ? ONES_INIT : 3'(b[0]);
                        ctx_n.in_frame = (b == HDLC_FLAG) ? 1'b1 : ctx.in_frame;
                    end
                    ctx_we = 1'b1;
                end
                if (wr_req)
                begin
                    s_d.wr.addr = cfg.base | (SSRAM_AW'(off) & span_mask);
                    s_d.wr_valid = 1'b1;
                    s_d.state = ST_WRITE;
                end
                else
                begin
                    s_d.state = (s_q.state == ST_PROC && s_q.cur.paired) ? ST_ODD : ST_FETCH;
                end
                if (s_q.state == ST_PROC && s_q.cur.paired)
                begin
                    s_d.byte_in = s_q.slot_bytes[{s_q.cur.sst[SST_STRM_HI:1], 1'b1}];
                    s_d.second = 1'b1;
                end
            end
            ST_WRITE:
            begin
                if (!s_q.wr_valid || ssram_ready)
                begin
                    s_d.state = ST_FETCH;
                    if (s_q.cur.paired && s_q.second)
                    begin
                        s_d.second = 1'b0;
                        s_d.state = ST_ODD;
                    end
                end
            end
            default: s_d.state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // table port and context updates
    always_ff @(posedge clk)
    begin
        if (assoc_we)
        begin
            assoc_mem[assoc_addr] <= assoc_wdata;
        end
        if (ctrl_we)
        begin
            ctrl_mem[ctrl_addr] <= ctrl_wdata;
        end
        if (ctrl_we && ctx_init)
        begin
            ctx_mem[ctrl_addr] <= '{ones: ONES_INIT, history: HIST_INIT, crc: CRC_INIT, default: '0};
        end
        else if (ctx_we)
        begin
            ctx_mem[idx] <= ctx_n;
        end
        if (rd_ptr_we)
        begin
            ctx_mem[rd_ptr_idx].read_ptr <= rd_ptr_value;
        end
    end

    assign ssram_wr        = s_q.wr;
    assign ssram_wr_valid  = s_q.wr_valid;
    assign loop_valid      = s_q.loop_v;
    assign loop_index      = s_q.loop_i;
    assign loop_data       = s_q.loop_d;
    assign pkt_event       = s_q.ev;
    assign pkt_event_valid = s_q.ev_v;
    assign cfg_error       = s_q.err; // sticky until reset

endmodule

/* verilog/tx_tdm_pkg.sv */
// Purpose: constants and carriers for the transmit tdm ingest path
// Assumes: 40 MHz clk, tdm bus clock sampled as a plain input
// Notes:   association and control tables are internal arrays loaded over a table port
package tx_tdm_pkg;

    // ========================================
    // sizes
    localparam int ASSOC_DEPTH     = 1024;
    localparam int ASSOC_AW        = 10;
    localparam int CTRL_DEPTH      = 1024;
    localparam int CTRL_AW         = 10;
    localparam int MAX_PCM_BUFS    = 1023;
    localparam int MAX_HDLC_STRMS  = 512;
    localparam int SSRAM_AW        = 21;
    localparam int NUM_STREAMS     = 32;
    localparam int SLOTS_PER_FRAME = 128;

    // ========================================
    // slot/stream number layout
    localparam int SST_W           = 12;
    localparam int SST_SLOT_HI     = 11;
    localparam int SST_SLOT_LO     = 5;
    localparam int SST_STRM_HI     = 4;
    localparam int SST_STRM_LO     = 0;
    localparam logic [SST_W-1:0] SST_ENTRY0 = 12'hfff;

    // ========================================
    // tag encoding: top bit selects loopback, low bits index
    localparam int TAG_W           = 11;
    localparam int TAG_LOOP_BIT    = 10;

    // ========================================
    // compression codes
    localparam logic [2:0] COMP_PCM      = 3'h0;
    localparam logic [2:0] COMP_AD40     = 3'h1;
    localparam logic [2:0] COMP_AD32     = 3'h2;
    localparam logic [2:0] COMP_AD24     = 3'h3;
    localparam logic [2:0] COMP_AD16     = 3'h4;
    localparam logic [2:0] COMP_AUTO_AD  = 3'h5;
    localparam logic [2:0] COMP_AUTO_ALL = 3'h6;
    localparam logic [2:0] COMP_RSVD     = 3'h7;

    // ========================================
    // buffer size codes, 256 bytes shifted by code
    localparam int BUF_MIN_LOG2    = 8;
    localparam logic [2:0] HDLC_BUF_MIN_CODE = 3'h1;
    localparam logic [2:0] PCM_BUF_MAX_CODE  = 3'h2;

    // ========================================
    // hdlc context
    localparam logic [2:0] ONES_INIT = 3'h7;
    localparam logic [7:0] HIST_INIT = 8'h01;
    localparam logic [7:0] HDLC_FLAG = 8'h7e;
    localparam logic [7:0] HDLC_ESC  = 8'h7d;
    localparam logic [7:0] ESC_XOR   = 8'h20;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_GOOD = 16'hf0b8;
    localparam logic [15:0] CRC_POLY = 16'h8408;

    typedef struct packed {
        logic [SST_W-1:0]  sst;
        logic              paired;
        logic [TAG_W-1:0]  tag;
        logic [ASSOC_AW-1:0] link;
    } assoc_entry_s;

    typedef struct packed {
        logic              is_hdlc;
        logic [SSRAM_AW-1:0] base;
        logic [2:0]        size_code;
        logic [2:0]        comp;
        logic              nibble_low;
        logic              in_law;
        logic              out_law;
        logic [1:0]        addr_bytes;
        logic              ctrl_byte;
        logic              crc_on;
        logic              framing_type;
    } ctrl_cfg_s;

    typedef struct packed {
        logic [14:0]       packet_start;
        logic [14:0]       write_offset;
        logic [14:0]       read_ptr;
        logic [8:0]        hdlc_address;
        logic [1:0]        header_count;
        logic [2:0]        ones;
        logic [7:0]        history;
        logic              escape;
        logic              in_frame;
        logic [15:0]       crc;
    } hdlc_ctx_s;

    typedef struct packed {
        logic [SSRAM_AW-1:0] addr;
        logic [7:0]        data;
    } ssram_wr_s;

    typedef struct packed {
        logic [8:0]        stream;
        logic [14:0]       start;
        logic [14:0]       length;
        logic [8:0]        hdlc_address;
        logic              crc_bad;
    } pkt_event_s;

endpackage

/* tb/tx_tdm_props.sv */
// Purpose: port checker for the transmit tdm ingest path
// Assumes: single clk domain, rst synchronous active high
// Notes:   bound to every instance of the design
`timescale 1ns/1ps
module tx_tdm_props
    import tx_tdm_pkg::*;
(
    input wire logic      clk,
    input wire logic      rst,
    input wire logic      ssram_ready,
    input wire ssram_wr_s ssram_wr,
    input wire logic      ssram_wr_valid,
    input wire logic      loop_valid,
    input wire logic      pkt_event_valid,
    input wire logic      cfg_error
);
    // ========================================
    // reset
    property p_rst_wr;
        @(posedge clk) rst |=> !ssram_wr_valid;
    endproperty
    property p_rst_pulse;
        @(posedge clk) rst |=> !loop_valid && !pkt_event_valid;
    endproperty
    property p_rst_err;
        @(posedge clk) rst |=> !cfg_error;
    endproperty
    // ========================================
    // ssram write handshake
    property p_wr_hold;
        @(posedge clk) disable iff (rst) ssram_wr_valid && !ssram_ready |=> ssram_wr_valid;
    endproperty
    property p_wr_stable;
        @(posedge clk) disable iff (rst) ssram_wr_valid && !ssram_ready |=> $stable(ssram_wr);
    endproperty
    property p_wr_nodup;
        @(posedge clk) disable iff (rst)
            ssram_wr_valid && ssram_ready |=> !(ssram_wr_valid && ssram_wr == $past(ssram_wr));
    endproperty
    // ========================================
    // one cycle pulses
    property p_loop_pulse;
        @(posedge clk) disable iff (rst) $rose(loop_valid) |=> $fell(loop_valid);
    endproperty
    property p_evt_pulse;
        @(posedge clk) disable iff (rst) pkt_event_valid |=> !pkt_event_valid;
    endproperty
    a_rst_wr: assert property (p_rst_wr) else $error("write valid after reset");
    a_rst_pulse: assert property (p_rst_pulse) else $error("pulse after reset");
    a_rst_err: assert property (p_rst_err) else $error("cfg error after reset");
    a_wr_hold: assert property (p_wr_hold) else $error("write dropped before ready");
    a_wr_stable: assert property (p_wr_stable) else $error("write changed before ready");
    a_wr_nodup: assert property (p_wr_nodup) else $error("write repeated");
    a_loop_pulse: assert property (p_loop_pulse) else $error("loop pulse too long");
    a_evt_pulse: assert property (p_evt_pulse) else $error("event pulse too long");
    c_wr_stall: cover property (@(posedge clk) ssram_wr_valid && !ssram_ready);
    c_loop: cover property (@(posedge clk) loop_valid);
    c_evt: cover property (@(posedge clk) pkt_event_valid);
endmodule

bind tx_tdm_ingest_path tx_tdm_props u_tx_tdm_props (.clk(clk), .rst(rst), .ssram_ready(ssram_ready),
    .ssram_wr(ssram_wr), .ssram_wr_valid(ssram_wr_valid), .loop_valid(loop_valid),
    .pkt_event_valid(pkt_event_valid), .cfg_error(cfg_error));

/* tb/tdm_bus_model.sv */
// Purpose: tdm bus source, one byte per slot and stream from a table
// Assumes: 200 ns bus clock, frame pulse on the first bit of slot 0
// Notes:   clock stands still until run; data changes 160 ns after each rise
`timescale 1ns/1ps
module tdm_bus_model
    import tx_tdm_pkg::*;
(
    input  logic                   run,
    input  logic [7:0]             tab [SLOTS_PER_FRAME][NUM_STREAMS],
    output logic                   tdm_clk,
    output logic                   tdm_frame,
    output logic [NUM_STREAMS-1:0] tdm_data
);
    initial
    begin
        tdm_clk   = 1'b0;
        tdm_frame = 1'b0;
        tdm_data  = '0;
        wait (run);
        forever
        begin
            for (int s = 0; s < SLOTS_PER_FRAME; s++)
            begin
                for (int b = 7; b >= 0; b--)
                begin
                    tdm_frame = (s == 0 && b == 7);
                    // msb first, stream t on line t
                    for (int t = 0; t < NUM_STREAMS; t++)
                        tdm_data[t] = tab[s][t][b];
                    #40 tdm_clk = 1'b1;
                    #100 tdm_clk = 1'b0;
                    #60;
                end
            end
        end
    end
endmodule

/* tb/tb_top.sv */
// Purpose: self-checking bench for the transmit tdm ingest path
// Assumes: 40 MHz clk, tables loaded before the bus starts
// Notes:   expected writes, loops and events are queued per frame
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin err_total++; \
    $display("ERROR %s exp %h got %h", nm, ex, got); end end
module tb_top
    import tx_tdm_pkg::*;
;
    logic                   clk, rst, tdm_clk, tdm_frame, run;
    logic [NUM_STREAMS-1:0] tdm_data;
    logic                   assoc_we, ctrl_we, ctx_init, rd_ptr_we, ssram_ready;
    logic [ASSOC_AW-1:0]    assoc_addr;
    logic [CTRL_AW-1:0]     ctrl_addr, rd_ptr_idx;
    logic [14:0]            rd_ptr_value;
    assoc_entry_s           assoc_wdata;
    ctrl_cfg_s              ctrl_wdata;
    ssram_wr_s              ssram_wr;
    logic                   ssram_wr_valid, loop_valid, pkt_event_valid, cfg_error;
    logic [TAG_W-2:0]       loop_index;
    logic [7:0]             loop_data;
    pkt_event_s             pkt_event;
    logic [7:0]             tab [SLOTS_PER_FRAME][NUM_STREAMS];
    logic [7:0]             hseq [6] = '{8'h7e, 8'h11, 8'h7d, 8'h5e, 8'h7e, 8'h7e};
    logic [49:0]            wq [$];
    logic [17:0]            lq [$];
    logic [48:0]            eq [$];
    logic [48:0]            ex;
    integer                 seed = 29536;
    int                     err_total = 0;
    int                     n_tests = 0;

    tx_tdm_ingest_path u_tx_tdm_ingest_path (.clk(clk), .rst(rst), .tdm_clk(tdm_clk), .tdm_frame(tdm_frame),
        .tdm_data(tdm_data), .assoc_we(assoc_we), .assoc_addr(assoc_addr), .assoc_wdata(assoc_wdata),
        .ctrl_we(ctrl_we), .ctrl_addr(ctrl_addr), .ctrl_wdata(ctrl_wdata), .ctx_init(ctx_init),
        .rd_ptr_we(rd_ptr_we), .rd_ptr_idx(rd_ptr_idx), .rd_ptr_value(rd_ptr_value),
        .ssram_ready(ssram_ready), .ssram_wr(ssram_wr), .ssram_wr_valid(ssram_wr_valid),
        .loop_valid(loop_valid), .loop_index(loop_index), .loop_data(loop_data),
        .pkt_event(pkt_event), .pkt_event_valid(pkt_event_valid), .cfg_error(cfg_error));
    tdm_bus_model u_tdm_bus_model (.run(run), .tab(tab), .tdm_clk(tdm_clk), .tdm_frame(tdm_frame),
        .tdm_data(tdm_data));

    // ========================================
    // helpers
    function automatic assoc_entry_s mk_a(input logic [11:0] s, input logic p, input logic [10:0] t,
                                          input logic [9:0] l);
        mk_a = '{sst: s, paired: p, tag: t, link: l};
    endfunction
    function automatic ctrl_cfg_s mk_c(input logic h, input logic [20:0] b, input logic [2:0] sz,
                                       input logic [2:0] cp, input logic lw, input logic ft);
        mk_c = '{is_hdlc: h, base: b, size_code: sz, comp: cp, in_law: lw, out_law: lw,
                 framing_type: ft, default: '0};
    endfunction
    task automatic wr_tab(input logic is_ctrl, input logic [9:0] a, input assoc_entry_s e, input ctrl_cfg_s c);
        @(posedge clk);
        #2;
        assoc_addr  = a;
        ctrl_addr   = a;
        assoc_wdata = e;
        ctrl_wdata  = c;
        assoc_we    = !is_ctrl;
        ctrl_we     = is_ctrl;
        ctx_init    = is_ctrl;
        @(posedge clk);
        #2;
        assoc_we = 1'b0;
        ctrl_we  = 1'b0;
        ctx_init = 1'b0;
    endtask
    task automatic finish_test();
        if (err_total == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic wait_frame();
        int k;
        for (k = 0; k < 20000 && tdm_frame !== 1'b0; k++) @(posedge clk);
        for (; k < 20000 && tdm_frame !== 1'b1; k++) @(posedge clk);
        if (k >= 20000)
        begin
            err_total++;
            finish_test();
        end
    endtask

    // ========================================
    // clock, ready stalls, output watcher
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        #2;
        ssram_ready = ($random(seed) & 3) != 0;
    end
    always @(posedge clk)
    begin
        if (!rst && ssram_wr_valid === 1'b1 && ssram_ready === 1'b1)
        begin
            if (wq.size() == 0)
                `CHK("extra write", 1'b0, 1'b1)
            else
            begin
                `CHK("write addr", wq[0][28:8], ssram_wr.addr & wq[0][49:29])
                `CHK("write data", wq[0][7:0], ssram_wr.data)
                void'(wq.pop_front());
            end
        end
        if (!rst && loop_valid === 1'b1)
        begin
            ex = (lq.size() > 0) ? {31'h0, lq.pop_front()} : '1;
            `CHK("loop", ex, {31'h0, loop_index, loop_data})
        end
        if (!rst && pkt_event_valid === 1'b1)
        begin
            ex = (eq.size() > 0) ? eq.pop_front() : '1;
            `CHK("event", ex, pkt_event)
        end
    end

    // ========================================
    // main sequence
    initial
    begin
        {rst, run, assoc_we, ctrl_we, ctx_init, rd_ptr_we} = 6'h20;
        {assoc_addr, ctrl_addr, rd_ptr_idx, rd_ptr_value, assoc_wdata, ctrl_wdata} = '0;
        ssram_ready = 1'b1;
        foreach (tab[s, t]) tab[s][t] = 8'($random(seed));
        tab[40][3] = HDLC_FLAG;
        repeat (20) @(posedge clk);
        #2;
        rst = 1'b0;
        @(posedge clk);
        #2;
        `CHK("cfg_error idle", 1'b0, cfg_error)
        wr_tab(0, 0, mk_a(SST_ENTRY0, 0, 11'h000, 1), '0);
        wr_tab(0, 1, mk_a({7'd3, 5'd2}, 0, 11'h005, 2), '0);
        wr_tab(0, 2, mk_a({7'd10, 5'd7}, 1, 11'h006, 3), '0);
        wr_tab(0, 3, mk_a({7'd20, 5'd0}, 0, 11'h409, 4), '0);
        wr_tab(0, 4, mk_a({7'd30, 5'd1}, 0, 11'h007, 5), '0);
        wr_tab(0, 5, mk_a({7'd40, 5'd3}, 0, 11'h008, 0), '0);
        wr_tab(1, 5, '0, mk_c(0, 21'h01000, 3'h0, COMP_AD32, 0, 0));
        wr_tab(1, 6, '0, mk_c(0, 21'h03000, 3'h0, COMP_PCM, 1, 0));
        wr_tab(1, 7, '0, mk_c(0, 21'h05000, 3'h0, COMP_RSVD, 0, 0));
        wr_tab(1, 8, '0, mk_c(1, 21'h04000, 3'h1, COMP_PCM, 0, 1));
        rd_ptr_idx = 10'd8;
        rd_ptr_we  = 1'b1;
        @(posedge clk);
        #2;
        rd_ptr_we = 1'b0;
        run       = 1'b1;
        for (int f = 0; f < 6; f++)
        begin
            wait_frame();
            foreach (tab[s, t]) tab[s][t] = 8'($random(seed));
            tab[40][3] = hseq[f];
            wq.push_back({21'h1fff00, 21'h01000, tab[3][2][7:4], 4'h0});
            wq.push_back({21'h1fff00, 21'h03000, tab[10][6]});
            wq.push_back({21'h1fff00, 21'h03000, tab[10][7]});
            lq.push_back({10'h009, tab[20][0]});
            if (f == 1) wq.push_back({21'h1fffff, 21'h04000, 8'h11});
            if (f == 3) wq.push_back({21'h1fffff, 21'h04001, HDLC_FLAG});
            if (f == 4) eq.push_back({9'd8, 15'h0, 15'h2, 9'h000, 1'b0});
        end
        wait_frame();
        `CHK("writes left", 0, wq.size())
        `CHK("loops left", 0, lq.size())
        `CHK("events left", 0, eq.size())
        `CHK("cfg_error reserved", 1'b1, cfg_error)
        finish_test();
    end
endmodule
